// ==== src/wmp_pkg.sv ====
// Purpose: shared constants for the write mask and preamble block
// Assumes: one 25 MHz clock, AXI4-Lite register access
// Notes:   offsets are byte addresses of 32-bit words
package wmp_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] WMP_OFF_MODE_REG_ZERO = 8'h00;
  localparam logic [7:0] WMP_OFF_MODE_REG_ONE  = 8'h04;
  localparam logic [7:0] WMP_OFF_MODE_REG_TWO  = 8'h08;
  localparam logic [7:0] WMP_OFF_MODE_REG_FOUR = 8'h0c;
  localparam logic [7:0] WMP_OFF_MODE_REG_FIVE = 8'h10;
  localparam logic [7:0] WMP_OFF_CONFIG        = 8'h14;
  localparam logic [7:0] WMP_OFF_STATUS        = 8'h18;
  localparam logic [7:0] WMP_OFF_CRC_CHECK     = 8'h1c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int WMP_BIT_TERM_STROBE = 11;  // mode_reg_one
  localparam int WMP_BIT_PRE_TRAIN   = 10;  // mode_reg_four
  localparam int WMP_BIT_RD_PRE      = 11;  // mode_reg_four
  localparam int WMP_BIT_WR_PRE      = 12;  // mode_reg_four
  localparam int WMP_BIT_CRC_ERR     = 3;   // mode_reg_five
  localparam int WMP_BIT_MASK_EN     = 10;  // mode_reg_five
  localparam int WMP_BIT_WR_INV      = 11;  // mode_reg_five
  localparam int WMP_BIT_RD_INV      = 12;  // mode_reg_five
  localparam int WMP_BIT_WR_CRC      = 0;   // config
  localparam int WMP_BIT_MPR_MODE    = 1;   // config
  localparam int WMP_LSB_WIDTH       = 2;   // config, 2 bits
  localparam int WMP_LSB_WLAT        = 3;   // mode_reg_two [5:3]
  localparam int WMP_LSB_WREC        = 9;   // mode_reg_zero [11:9]

  // ----------------------------------------
  // values and counts
  // ----------------------------------------
  localparam logic [1:0]  WMP_ORG_X4      = 2'h0;
  localparam logic [1:0]  WMP_ORG_X8      = 2'h1;
  localparam logic [1:0]  WMP_ORG_X16     = 2'h2;
  localparam logic [31:0] WMP_RST_CONFIG  = 32'h0000_0004;  // x8
  localparam logic [31:0] WMP_RST_MODE    = 32'h0000_0000;
  localparam int          WMP_BEATS       = 8;
  localparam logic [2:0]  WMP_LAST_BEAT   = 3'h7;
  localparam logic [3:0]  WMP_PRE_ONE_CLK = 4'h1;
  localparam logic [3:0]  WMP_PRE_TWO_CLK = 4'h2;
  localparam logic [1:0]  WMP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  WMP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WMP_IDLE,
    WMP_BURST,
    WMP_COMMIT
  } wmp_state_t;

endpackage

// ==== src/wmp_top.sv ====
// Purpose: write-mask, shared-pin function select and preamble mode logic
// Assumes: link strobe and pins arrive unsynchronised; one beat per rising strobe edge
// Notes:   the controller keeps its own spacing and latency choices
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module wmp_top
  import wmp_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link pins
  input  wire logic        data_strobe,
  input  wire logic        write_burst,
  input  wire logic [15:0] data_pins,
  input  wire logic        lower_byte_mask_pin,
  input  wire logic        upper_byte_mask_pin,
  // array side
  output logic             array_we,
  output logic [15:0]      array_data,
  output logic [15:0]      array_byte_en,
  output logic [2:0]       array_beat,
  output logic             write_preamble_two,
  output logic             read_preamble_two,
  output logic             preamble_training
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] mode_zero_q, mode_one_q, mode_two_q, mode_four_q, mode_five_q, config_q;
  logic        crc_ok_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        crc_fail_set;
  wmp_state_t  state_q;

  function automatic logic [31:0] wmp_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire logic do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire logic [1:0] org = config_q[WMP_LSB_WIDTH +: 2];
  // mask only exists on byte-wide and sixteen-bit parts
  wire logic mask_on = mode_five_q[WMP_BIT_MASK_EN] && (org != WMP_ORG_X4);
  wire logic crc_on  = config_q[WMP_BIT_WR_CRC];
  wire logic busy    = (state_q != WMP_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WMP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q > WMP_OFF_CRC_CHECK || aw_addr_q[1:0] != 2'h0) ? WMP_RESP_SLVERR : WMP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_zero_q <= WMP_RST_MODE;
      mode_one_q  <= WMP_RST_MODE;
      mode_two_q  <= WMP_RST_MODE;
      mode_four_q <= WMP_RST_MODE;
      config_q    <= WMP_RST_CONFIG;
      crc_ok_q    <= 1'b1;
    end else if (do_write) begin
      case (aw_addr_q)
        WMP_OFF_MODE_REG_ZERO: mode_zero_q <= wmp_merge(mode_zero_q, w_data_q, w_strb_q);
        WMP_OFF_MODE_REG_ONE:  mode_one_q  <= wmp_merge(mode_one_q, w_data_q, w_strb_q);
        WMP_OFF_MODE_REG_TWO:  mode_two_q  <= wmp_merge(mode_two_q, w_data_q, w_strb_q);
        WMP_OFF_MODE_REG_FOUR: begin
          mode_four_q <= wmp_merge(mode_four_q, w_data_q, w_strb_q);
          // training may only be entered while in register access mode
          if (!config_q[WMP_BIT_MPR_MODE]) begin
            mode_four_q[WMP_BIT_PRE_TRAIN] <= 1'b0;
          end
        end
        WMP_OFF_CONFIG:        config_q    <= wmp_merge(config_q, w_data_q, w_strb_q);
        WMP_OFF_CRC_CHECK:     crc_ok_q    <= w_data_q[0];
        default: ;
      endcase
    end
  end

  // crc error flag: a new failure wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_five_q <= WMP_RST_MODE;
    end else begin
      if (do_write && aw_addr_q == WMP_OFF_MODE_REG_FIVE) begin
        mode_five_q <= wmp_merge(mode_five_q, w_data_q, w_strb_q);
      end
      if (crc_fail_set) begin
        mode_five_q[WMP_BIT_CRC_ERR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= WMP_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= WMP_RESP_OKAY;
      case (s_axi_araddr)
        WMP_OFF_MODE_REG_ZERO: s_axi_rdata <= mode_zero_q;
        WMP_OFF_MODE_REG_ONE:  s_axi_rdata <= mode_one_q;
        WMP_OFF_MODE_REG_TWO:  s_axi_rdata <= mode_two_q;
        WMP_OFF_MODE_REG_FOUR: s_axi_rdata <= mode_four_q;
        WMP_OFF_MODE_REG_FIVE: s_axi_rdata <= mode_five_q;
        WMP_OFF_CONFIG:        s_axi_rdata <= config_q;
        WMP_OFF_STATUS:        s_axi_rdata <= {29'h0, mask_on, array_we, busy};
        WMP_OFF_CRC_CHECK:     s_axi_rdata <= {31'h0, crc_ok_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= WMP_RESP_SLVERR;
        end
      endcase
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // ----------------------------------------
  // preamble selection
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_preamble_two <= 1'b0;
      read_preamble_two  <= 1'b0;
      preamble_training  <= 1'b0;
    end else begin
      write_preamble_two <= mode_four_q[WMP_BIT_WR_PRE];
      read_preamble_two  <= mode_four_q[WMP_BIT_RD_PRE];
      preamble_training  <= mode_four_q[WMP_BIT_PRE_TRAIN] && config_q[WMP_BIT_MPR_MODE];
    end
  end

  // ----------------------------------------
  // link sampling
  // ----------------------------------------
  logic [19:0] sync1_q, sync2_q;
  logic        strobe_d1_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q     <= 20'h00000;
      sync2_q     <= 20'h00000;
      strobe_d1_q <= 1'b0;
    end else begin
      sync1_q     <= {data_strobe, write_burst, upper_byte_mask_pin, lower_byte_mask_pin, data_pins};
      sync2_q     <= sync1_q;
      strobe_d1_q <= sync2_q[19];
    end
  end
  wire logic beat_edge = sync2_q[19] && !strobe_d1_q;

  // ----------------------------------------
  // burst capture and commit
  // ----------------------------------------
  logic [2:0]   beat_q;
  logic [15:0]  buf_data_q [WMP_BEATS];
  logic [15:0]  buf_en_q   [WMP_BEATS];
  logic [2:0]   out_q;
  // pin low means masked; a disabled mask ignores the pin entirely
  wire logic [1:0] keep = mask_on ? sync2_q[17:16] : 2'h3;
  wire logic upper_ok = (org == WMP_ORG_X16);
  // with mask on, bad crc is persistent and blocks the whole burst
  wire logic commit_ok = !(crc_on && mask_on && !crc_ok_q);
  assign crc_fail_set = (state_q == WMP_BURST) && beat_edge && beat_q == WMP_LAST_BEAT && crc_on && !crc_ok_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= WMP_IDLE;
      beat_q  <= 3'h0;
      out_q   <= 3'h0;
    end else begin
      case (state_q)
        WMP_IDLE: begin
          beat_q <= 3'h0;
          if (beat_edge && sync2_q[18]) begin
            state_q <= WMP_BURST;
            beat_q  <= 3'h1;
          end
        end
        WMP_BURST: if (beat_edge) begin
          beat_q <= beat_q + 3'h1;
          if (beat_q == WMP_LAST_BEAT) begin
            state_q <= commit_ok ? WMP_COMMIT : WMP_IDLE;
            out_q   <= 3'h0;
          end
        end
        WMP_COMMIT: begin
          out_q <= out_q + 3'h1;
          if (out_q == WMP_LAST_BEAT) begin
            state_q <= WMP_IDLE;
          end
        end
        default: state_q <= WMP_IDLE;
      endcase
    end
  end

  // lower mask pairs with bits 7:0, upper with 15:8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < WMP_BEATS; i++) begin
        buf_data_q[i] <= 16'h0000;
        buf_en_q[i]   <= 16'h0000;
      end
    end else if (beat_edge && (state_q == WMP_BURST || (state_q == WMP_IDLE && sync2_q[18]))) begin
      buf_data_q[beat_q] <= sync2_q[15:0];
      buf_en_q[beat_q]   <= {{8{keep[1] && upper_ok}}, {8{keep[0]}}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      array_we      <= 1'b0;
      array_data    <= 16'h0000;
      array_byte_en <= 16'h0000;
      array_beat    <= 3'h0;
    end else begin
      array_we      <= (state_q == WMP_COMMIT);
      array_data    <= buf_data_q[out_q];
      array_byte_en <= buf_en_q[out_q];
      array_beat    <= out_q;
    end
  end

endmodule

// ==== testbench/wmp_top_checker.sv ====
// Purpose: port-level assertions for wmp_top
// Assumes: register writes carry every byte strobe
// Notes:   shadows the few mode bits the assertions need
`timescale 1ns/1ps
module wmp_top_checker
  import wmp_pkg::*;
(
  // clock, reset and register writes
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // array side and mode levels
  input wire logic        array_we,
  input wire logic [15:0] array_byte_en,
  input wire logic [2:0]  array_beat,
  input wire logic        write_preamble_two,
  input wire logic        read_preamble_two,
  input wire logic        preamble_training
);
  logic [7:0]  addr_q;
  logic [31:0] data_q;
  logic        mask_q, mpr_q;
  logic [1:0]  org_q;
  logic        done, to_four;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign done    = s_axi_bvalid && s_axi_bready;
  assign to_four = done && addr_q == WMP_OFF_MODE_REG_FOUR;

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) addr_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) data_q <= s_axi_wdata;
  end

  // ----------------------------------------
  // shadow of mask, mode and organisation
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= 1'b0;
      mpr_q  <= 1'b0;
      org_q  <= WMP_ORG_X8;
    end else if (done && addr_q == WMP_OFF_MODE_REG_FIVE) begin
      mask_q <= data_q[WMP_BIT_MASK_EN];
    end else if (done && addr_q == WMP_OFF_CONFIG) begin
      mpr_q <= data_q[WMP_BIT_MPR_MODE];
      org_q <= data_q[WMP_LSB_WIDTH +: 2];
    end
  end

  sequence commit_s;
    array_we [*8] ##1 !array_we;
  endsequence

  burst_len_a: assert property ($rose(array_we) |-> commit_s) else $error("commit length");
  beat_zero_a: assert property ($rose(array_we) |-> array_beat == 3'h0) else $error("first beat");
  beat_step_a: assert property (array_we && $past(array_we) |-> array_beat == $past(array_beat) + 3'h1)
    else $error("beat order");
  whole_lane_a: assert property (array_we |-> array_byte_en[7:0] inside {8'h00, 8'hff})
    else $error("lane split");
  no_mask_a: assert property (array_we && (!mask_q || org_q == WMP_ORG_X4) |-> array_byte_en[7:0] == 8'hff)
    else $error("byte dropped");
  upper_off_a: assert property (array_we && org_q != WMP_ORG_X16 |-> array_byte_en[15:8] == 8'h00)
    else $error("upper lane");
  wr_pre_a: assert property (to_four |-> ##2 write_preamble_two == data_q[WMP_BIT_WR_PRE])
    else $error("write preamble");
  rd_pre_a: assert property (to_four |-> ##2 read_preamble_two == data_q[WMP_BIT_RD_PRE])
    else $error("read preamble");
  train_mode_a: assert property (to_four |-> ##2 preamble_training == (data_q[WMP_BIT_PRE_TRAIN] && mpr_q))
    else $error("training level");
endmodule

bind wmp_top wmp_top_checker wmp_top_checker_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .array_we, .array_byte_en, .array_beat,
  .write_preamble_two, .read_preamble_two, .preamble_training
);

// ==== testbench/wmp_link_model.sv ====
// Purpose: controller-side model driving write bursts on the link
// Assumes: one burst per rising edge of go
// Notes:   strobe idles low; released lanes show inverted data
`timescale 1ns/1ps
module wmp_link_model (
  // bench control
  input  wire logic        go,
  input  wire logic [15:0] pat,
  input  wire logic [7:0]  lo_m,
  input  wire logic [7:0]  hi_m,
  // link pins
  output logic             data_strobe,
  output logic             write_burst,
  output logic [15:0]      data_pins,
  output logic             lower_byte_mask_pin,
  output logic             upper_byte_mask_pin
);
  initial begin
    {data_strobe, write_burst} = 2'h0;
    data_pins = 16'h0000;
    {lower_byte_mask_pin, upper_byte_mask_pin} = 2'h3;
  end

  // single bursts far apart, so spacing never hits five or six clocks
  always @(posedge go) begin
    for (int i = 0; i < 8; i++) begin
      data_pins = pat + 16'h0101 * i[15:0];
      lower_byte_mask_pin = lo_m[i];
      upper_byte_mask_pin = hi_m[i];
      write_burst = (i == 0);
      // odd offsets keep strobe edges off the aclk grid
      #87 data_strobe = 1'b1;
      #160 data_strobe = 1'b0;
      #73;
    end
    write_burst = 1'b0;
    data_pins = ~data_pins;
    lower_byte_mask_pin = ~lower_byte_mask_pin;
    upper_byte_mask_pin = ~upper_byte_mask_pin;
  end
endmodule

// ==== testbench/wmp_top_tb.sv ====
// Purpose: self-checking bench for wmp_top
// Assumes: link model sends one burst at a time
// Notes:   register writes use full byte strobes
`timescale 1ns/1ps
module wmp_top_tb
  import wmp_pkg::*;
;
  logic        aclk, aresetn, go;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, lo_m, hi_m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        data_strobe, write_burst, lower_byte_mask_pin, upper_byte_mask_pin;
  logic [15:0] data_pins, array_data, array_byte_en, pat;
  logic        array_we, write_preamble_two, read_preamble_two, preamble_training;
  logic [2:0]  array_beat;
  int          num_errors, total_checks;

  wmp_top wmp_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .data_strobe, .write_burst, .data_pins, .lower_byte_mask_pin, .upper_byte_mask_pin, .array_we,
    .array_data, .array_byte_en, .array_beat, .write_preamble_two, .read_preamble_two, .preamble_training
  );
  wmp_link_model wmp_link_model_inst (
    .go, .pat, .lo_m, .hi_m, .data_strobe, .write_burst, .data_pins, .lower_byte_mask_pin, .upper_byte_mask_pin
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one write or one read; for a read d is the expected data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    if (w) {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    else {s_axi_arvalid, s_axi_rready} <= 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    chk("resp", 32'(er), 32'(w ? s_axi_bresp : s_axi_rresp));
    if (!w) chk("rdata", d, s_axi_rdata);
    repeat (2) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, WMP_RESP_OKAY);
  endtask

  // one link burst; expected lanes follow mask, organisation and commit
  task automatic burst(input logic [1:0] org, input logic men, input logic [7:0] lo, hi, input logic cmt);
    logic [15:0] en;
    int c;
    c = 0;
    // pattern and masks settle a cycle before go, so the model never reads stale ones
    {lo_m, hi_m} <= {lo, hi};
    pat <= pat + 16'h1111;
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (160) begin
      @(posedge aclk);
      #1;
      if (array_we === 1'b1) begin
        en[7:0] = (men && org != WMP_ORG_X4 && !lo[c]) ? 8'h00 : 8'hff;
        en[15:8] = (org != WMP_ORG_X16 || (men && !hi[c])) ? 8'h00 : 8'hff;
        chk("beat", c, 32'(array_beat));
        chk("byte_en", 32'(en), 32'(array_byte_en));
        chk("data", 32'((pat + 16'h0101 * c[15:0]) & en), 32'(array_data & en));
        c++;
      end
    end
    chk("beats", cmt ? 8 : 0, c);
    @(posedge aclk);
  endtask

  task automatic t_regs();
    bus(1'b0, WMP_OFF_CONFIG, WMP_RST_CONFIG, WMP_RESP_OKAY);
    bus(1'b0, WMP_OFF_MODE_REG_FOUR, WMP_RST_MODE, WMP_RESP_OKAY);
    bus(1'b0, WMP_OFF_CRC_CHECK, 32'h1, WMP_RESP_OKAY);
    bus(1'b0, 8'h20, 32'h0, WMP_RESP_SLVERR);
    bus(1'b1, 8'h22, 32'hffff_ffff, WMP_RESP_SLVERR);
  endtask

  task automatic t_pre();
    // link carries no rate; two-clock runs stand for fast parts with a matching latency
    wr(WMP_OFF_MODE_REG_TWO, 32'h1 << WMP_LSB_WLAT);
    bus(1'b0, WMP_OFF_MODE_REG_TWO, 32'h1 << WMP_LSB_WLAT, WMP_RESP_OKAY);
    // recovery left at its normal code: no extra clock for the long preamble
    wr(WMP_OFF_MODE_REG_ZERO, 32'h1 << WMP_LSB_WREC);
    bus(1'b0, WMP_OFF_MODE_REG_ZERO, 32'h1 << WMP_LSB_WREC, WMP_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(WMP_OFF_MODE_REG_FOUR, 32'(i) << WMP_BIT_RD_PRE);
      chk("wr_pre", 32'(i >> 1), 32'(write_preamble_two));
      chk("rd_pre", 32'(i & 1), 32'(read_preamble_two));
    end
    wr(WMP_OFF_MODE_REG_FOUR, 32'h400);
    chk("train", 32'h0, 32'(preamble_training));
    wr(WMP_OFF_CONFIG, 32'h6);
    wr(WMP_OFF_MODE_REG_FOUR, 32'h400);
    chk("train", 32'h1, 32'(preamble_training));
    wr(WMP_OFF_MODE_REG_FOUR, 32'h0);
  endtask

  task automatic t_mask();
    wr(WMP_OFF_CONFIG, WMP_RST_CONFIG);
    wr(WMP_OFF_MODE_REG_FIVE, 32'h400);
    bus(1'b0, WMP_OFF_STATUS, 32'h4, WMP_RESP_OKAY);
    burst(WMP_ORG_X8, 1'b1, 8'ha5, 8'h3c, 1'b1);
    wr(WMP_OFF_MODE_REG_FIVE, 32'h1400);
    wr(WMP_OFF_CONFIG, 32'h8);
    burst(WMP_ORG_X16, 1'b1, 8'h5a, 8'hc3, 1'b1);
  endtask

  task automatic t_unmasked();
    wr(WMP_OFF_CONFIG, 32'h0);
    bus(1'b0, WMP_OFF_STATUS, 32'h0, WMP_RESP_OKAY);
    burst(WMP_ORG_X4, 1'b1, 8'h00, 8'h0f, 1'b1);
    wr(WMP_OFF_MODE_REG_FIVE, 32'h0);
    wr(WMP_OFF_CONFIG, 32'h8);
    burst(WMP_ORG_X16, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask

  task automatic t_crc();
    wr(WMP_OFF_CONFIG, 32'h5);
    wr(WMP_OFF_MODE_REG_FIVE, 32'h400);
    wr(WMP_OFF_CRC_CHECK, 32'h0);
    burst(WMP_ORG_X8, 1'b1, 8'hff, 8'hff, 1'b0);
    bus(1'b0, WMP_OFF_MODE_REG_FIVE, 32'h408, WMP_RESP_OKAY);
    wr(WMP_OFF_MODE_REG_FIVE, 32'h0);
    wr(WMP_OFF_CRC_CHECK, 32'h0);
    burst(WMP_ORG_X8, 1'b0, 8'h00, 8'h00, 1'b1);
    bus(1'b0, WMP_OFF_MODE_REG_FIVE, 32'h8, WMP_RESP_OKAY);
  endtask

  // about 1200 cycles of tests; the margin only cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test();
  end

  initial begin
    {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lo_m, hi_m, pat} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_pre();
    t_mask();
    t_unmasked();
    t_crc();
    finish_test();
  end
endmodule
